// >>> dv/adcsc_top_tb.sv
// self-checking bench for the converter status and control block
`timescale 1ns/1ps
module adcsc_top_tb;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic        clk       = 1'b0;
    logic        rstn      = 1'b0;
    logic        cyc       = 1'b0;
    logic        stb       = 1'b0;
    logic        we        = 1'b0;
    logic [7:0]  adr       = 8'h00;
    logic [3:0]  sel       = 4'h0;
    logic [31:0] wdat      = 32'h0000_0000;
    logic        reg_start = 1'b0;
    logic        inj_start = 1'b0;
    logic        conv_done = 1'b0;
    logic        conv_inj  = 1'b0;
    logic        conv_last = 1'b0;
    logic [4:0]  conv_ch   = 5'h00;
    logic [9:0]  conv_dat  = 10'h000;
    logic [31:0] rdat;
    logic        ack;
    logic [1:0]  cal;
    logic [2:0]  bcnt;
    logic        ibm;
    logic        rbm;
    logic        scan;
    logic        ainj;
    logic [31:0] rd;
    int          errors    = 0;
    int          tests_run = 0;
    int          i;
    // patterns keep burst to one group and never pair it with auto injection
    logic [31:0] vals [3]  = '{32'hffff_f3ff, 32'h0000_0000, 32'h0440_4a5c};
    // watchdog table: expected flag, injected, channel, data, control one
    logic [48:0] wd [10]   = '{
        {1'b1, 1'b0, 5'h00, 10'h201, 32'h0280_0000},  // above high
        {1'b0, 1'b0, 5'h00, 10'h200, 32'h0280_0000},  // equal to high
        {1'b1, 1'b0, 5'h00, 10'h0ff, 32'h0280_0000},  // below low
        {1'b0, 1'b0, 5'h00, 10'h100, 32'h0280_0000},  // equal to low
        {1'b0, 1'b1, 5'h00, 10'h300, 32'h0280_0000},  // injected not guarded
        {1'b1, 1'b1, 5'h00, 10'h300, 32'h0240_0000},  // injected guarded
        {1'b0, 1'b0, 5'h00, 10'h300, 32'h0240_0000},  // regular not guarded
        {1'b0, 1'b0, 5'h04, 10'h300, 32'h0280_0203},  // other channel
        {1'b1, 1'b0, 5'h03, 10'h300, 32'h0280_0203},  // named channel
        {1'b1, 1'b0, 5'h04, 10'h300, 32'h0280_0003}}; // all channels

    // ------------------------------------------------------------
    // clock and device
    // ------------------------------------------------------------
    always #5 clk = ~clk;

    adcsc_top u_dut (
        .clk                        (clk),
        .rstn                       (rstn),
        .wb_cyc_i                   (cyc),
        .wb_stb_i                   (stb),
        .wb_we_i                    (we),
        .wb_adr_i                   (adr),
        .wb_sel_i                   (sel),
        .wb_dat_i                   (wdat),
        .wb_dat_o                   (rdat),
        .wb_ack_o                   (ack),
        .reg_start                  (reg_start),
        .inj_start                  (inj_start),
        .conv_done                  (conv_done),
        .conv_inj                   (conv_inj),
        .conv_last                  (conv_last),
        .conv_channel               (conv_ch),
        .conv_data                  (conv_dat),
        .calibration_voltage_select (cal),
        .burst_channel_count        (bcnt),
        .injected_burst_mode_enable (ibm),
        .regular_burst_mode_enable  (rbm),
        .scan_enable                (scan),
        .auto_inj_start             (ainj)
    );

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    // verdict and end of run
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // compare seen against expected
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one classic cycle; rs raises a regular start at the edge the access lands
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic rs, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'hf;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
            if (ack !== 1'b1) begin
                reg_start <= rs;
            end
            if (n > 20) begin
                errors++;
                report_and_stop();
            end
        end while (ack !== 1'b1);
        q = rdat;
        cyc       <= 1'b0;
        stb       <= 1'b0;
        we        <= 1'b0;
        reg_start <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 1'b0, rd);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0, 1'b0, rd);
        check(rd, exp);
    endtask

    // one-cycle engine event pulse, returns just after the edge that samples it
    task automatic ev(input logic rs, input logic is, input logic dn, input logic inj,
                      input logic last, input logic [4:0] c, input logic [9:0] d);
        @(posedge clk);
        reg_start <= rs;
        inj_start <= is;
        conv_done <= dn;
        conv_inj  <= inj;
        conv_last <= last;
        conv_ch   <= c;
        conv_dat  <= d;
        @(posedge clk);
        reg_start <= 1'b0;
        inj_start <= 1'b0;
        conv_done <= 1'b0;
        #1;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        // reset values
        rdc(8'h00, 32'h0000_0000);
        rdc(8'h04, 32'h0200_0000);
        check({30'h0, cal}, 32'h0000_0001);
        rdc(8'h24, 32'h0000_03ff);
        // control fields, reserved bits and outputs
        for (i = 0; i < 3; i++) begin
            wr(8'h04, vals[i]);
            rdc(8'h04, vals[i] & 32'h06c0_ffff);
            check({26'h0, cal, bcnt, ibm}, {26'h0, vals[i][26:25], vals[i][15:12]});
            check({30'h0, rbm, scan}, {30'h0, vals[i][11], vals[i][8]});
        end
        wr(8'h10, 32'hffff_ffff);
        rdc(8'h10, 32'h0000_0000);
        // status flags set by events, cleared by writing 0
        wr(8'h04, 32'h0200_0000);
        ev(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00, 10'h000);
        rdc(8'h00, 32'h0000_0010);
        ev(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 5'h00, 10'h000);
        rdc(8'h00, 32'h0000_0018);
        ev(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 5'h02, 10'h3ff);
        rdc(8'h00, 32'h0000_0018);
        ev(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 5'h02, 10'h3ff);
        rdc(8'h00, 32'h0000_001e);
        wr(8'h00, 32'hffff_ffff);
        rdc(8'h00, 32'h0000_001e);
        wr(8'h00, 32'h0000_0015);
        rdc(8'h00, 32'h0000_0014);
        wr(8'h00, 32'h0000_0000);
        rdc(8'h00, 32'h0000_0000);
        // regular group end, then a result read clears the done flag
        ev(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 5'h01, 10'h2a5);
        rdc(8'h00, 32'h0000_0002);
        rdc(8'h4c, 32'h0000_02a5);
        rdc(8'h00, 32'h0000_0000);
        // clear and hardware set landing on the same edge
        wb(1'b1, 8'h00, 32'h0000_0000, 1'b1, rd);
        rdc(8'h00, 32'h0000_0010);
        wr(8'h00, 32'h0000_0000);
        // watchdog window and channel selection
        wr(8'h24, 32'hffff_fe00);
        rdc(8'h24, 32'h0000_0200);
        wr(8'h28, 32'h0000_0100);
        for (i = 0; i < 10; i++) begin
            wr(8'h04, wd[i][31:0]);
            ev(1'b0, 1'b0, 1'b1, wd[i][47], 1'b0, wd[i][46:42], wd[i][41:32]);
            rdc(8'h00, {31'h0, wd[i][48]});
            wr(8'h00, 32'h0000_0000);
        end
        // automatic injection after a regular group end
        // no injected start pulse is given while auto injection is on
        wr(8'h04, 32'h0200_0400);
        ev(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 5'h00, 10'h150);
        check({31'h0, ainj}, 32'h0000_0001);
        @(posedge clk);
        #1;
        check({31'h0, ainj}, 32'h0000_0000);
        ev(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 5'h00, 10'h150);
        check({31'h0, ainj}, 32'h0000_0000);
        wr(8'h04, 32'h0200_0000);
        ev(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 5'h00, 10'h150);
        check({31'h0, ainj}, 32'h0000_0000);
        report_and_stop();
    end
endmodule // adcsc_top_tb

// >>> rtl/adcsc_flag.sv
// one sticky status flag: hardware sets, software clears
`timescale 1ns/1ps
module adcsc_flag (
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // set and clear requests
    input  wire logic hw_set,
    input  wire logic sw_clear,
    // flag state
    output logic      flag
);
    logic next_flag;

    always_comb begin
        next_flag = flag;
        if (sw_clear) begin
            next_flag = 1'b0;
        end
        if (hw_set) begin
            next_flag = 1'b1;
        end
    end

    // flag register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag <= adcsc_pkg::FLAG_RST;
        end else begin
            flag <= next_flag;
        end
    end
endmodule // adcsc_flag

// >>> rtl/adcsc_pkg.sv
// constants shared by the converter status and control block
// How it works
// - hardware sets status bit 4 when a regular-group conversion begins; resets to zero
// - hardware sets status bit 3 when an injected-group conversion begins; resets to zero
// - bit 2 is set only once every injected channel is converted
// - writing 0 to a status flag clears it, writing 1 leaves it
// - bit 1 is set when the regular or injected group finishes
// - reading the regular result register also clears bit 1
// - bit 0 is set when a converted value leaves the threshold window
// - calibration voltage field 26:25: 01 half, 10 three quarters; resets to 01
// - control bit 23 turns on the watchdog for regular-group conversions
// - control bit 22 turns on the watchdog for injected-group conversions
// - field 15:13 gives channels per trigger in burst mode, code plus one
// - control bit 12 turns burst mode on for the injected group
// - control bit 11 turns burst mode on for the regular group
// - control bit 10 starts the injected group after the regular group ends
// - control bit 9 chooses one guarded channel or all channels for the watchdog
// - single select 1 compares only the named channel, 0 compares every channel
// - the watchdog uses only the low 10 bits of both thresholds
package adcsc_pkg;
    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS  = 8'h00;
    localparam logic [7:0] OFS_CTRL1   = 8'h04;
    localparam logic [7:0] OFS_WD_HIGH = 8'h24;
    localparam logic [7:0] OFS_WD_LOW  = 8'h28;
    localparam logic [7:0] OFS_RESULT  = 8'h4c;

    // ---------------------------------------------------------------
    // status flag positions
    // ---------------------------------------------------------------
    localparam int STAT_W        = 5;
    localparam int BIT_REG_START = 4;
    localparam int BIT_INJ_START = 3;
    localparam int BIT_INJ_DONE  = 2;
    localparam int BIT_CONV_DONE = 1;
    localparam int BIT_WATCHDOG  = 0;

    // ---------------------------------------------------------------
    // control register one field positions
    // ---------------------------------------------------------------
    localparam int CAL_LSB       = 25;
    localparam int REG_WD_EN     = 23;
    localparam int INJ_WD_EN     = 22;
    localparam int BURST_CNT_LSB = 13;
    localparam int INJ_BURST     = 12;
    localparam int REG_BURST     = 11;
    localparam int AUTO_INJ      = 10;
    localparam int WD_SGL        = 9;
    localparam int SCAN          = 8;
    localparam int WD_CH_LSB     = 0;

    // ---------------------------------------------------------------
    // reset values and writable masks
    // ---------------------------------------------------------------
    localparam logic        FLAG_RST    = 1'b0;
    localparam logic [31:0] CTRL1_RST   = 32'h0200_0000;
    localparam logic [31:0] CTRL1_MASK  = 32'h06c0_ffff;
    localparam logic [9:0]  WD_HIGH_RST = 10'h3ff;
    localparam logic [9:0]  WD_LOW_RST  = 10'h000;
    localparam logic [9:0]  RESULT_RST  = 10'h000;
endpackage

// >>> rtl/adcsc_top.sv
// converter status flags, control register one and watchdog over wishbone
`timescale 1ns/1ps
module adcsc_top #(
    parameter int DATA_W = 10,
    parameter int CH_W   = 5
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // wishbone classic slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // conversion engine events
    input  wire logic              reg_start,
    input  wire logic              inj_start,
    input  wire logic              conv_done,
    input  wire logic              conv_inj,
    input  wire logic              conv_last,
    input  wire logic [CH_W-1:0]   conv_channel,
    input  wire logic [DATA_W-1:0] conv_data,
    // control towards the engine
    output logic      [1:0]        calibration_voltage_select,
    output logic      [2:0]        burst_channel_count,
    output logic                   injected_burst_mode_enable,
    output logic                   regular_burst_mode_enable,
    output logic                   scan_enable,
    output logic                   auto_inj_start
);
    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    logic [adcsc_pkg::STAT_W-1:0] status;
    logic [adcsc_pkg::STAT_W-1:0] flag_set;
    logic [adcsc_pkg::STAT_W-1:0] flag_clr;
    logic [31:0]                  ctrl1;
    logic [31:0]                  next_ctrl1;
    logic [31:0]                  merged;
    logic [DATA_W-1:0]            wd_high;
    logic [DATA_W-1:0]            next_wd_high;
    logic [DATA_W-1:0]            wd_low;
    logic [DATA_W-1:0]            next_wd_low;
    logic [DATA_W-1:0]            result;
    logic [DATA_W-1:0]            next_result;
    logic [31:0]                  next_dat;
    logic                         next_ack;
    logic                         next_auto;
    logic                         req;
    logic                         wr_take;
    logic                         rd_take;
    logic                         hit_stat;
    logic                         hit_ctrl;
    logic                         hit_high;
    logic                         hit_low;
    logic                         hit_res;
    logic                         wd_outside;
    logic                         wd_group_on;
    logic                         wd_chan_on;
    logic                         wd_event;
    logic                         reg_group_end;

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    // request pending and the edge at which it is taken
    assign req      = wb_cyc_i && wb_stb_i;
    assign wr_take  = req && wb_we_i && wb_ack_o;
    assign rd_take  = req && !wb_we_i && wb_ack_o;
    assign hit_stat = wb_adr_i[7:2] == adcsc_pkg::OFS_STATUS[7:2];
    assign hit_ctrl = wb_adr_i[7:2] == adcsc_pkg::OFS_CTRL1[7:2];
    assign hit_high = wb_adr_i[7:2] == adcsc_pkg::OFS_WD_HIGH[7:2];
    assign hit_low  = wb_adr_i[7:2] == adcsc_pkg::OFS_WD_LOW[7:2];
    assign hit_res  = wb_adr_i[7:2] == adcsc_pkg::OFS_RESULT[7:2];

    // byte lane merge of write data over control register one
    always_comb begin
        merged = ctrl1;
        for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
                merged[8*b +: 8] = wb_dat_i[8*b +: 8];
            end
        end
    end

    // ---------------------------------------------------------------
    // bus answer: one wait state, registered ack and read data
    // ---------------------------------------------------------------
    // read mux, loaded when the ack is raised
    always_comb begin
        next_ack = req && !wb_ack_o;
        next_dat = 32'h0000_0000;
        if (next_ack && !wb_we_i) begin
            if (hit_stat) begin
                next_dat[adcsc_pkg::STAT_W-1:0] = status;
            end else if (hit_ctrl) begin
                next_dat = ctrl1;
            end else if (hit_high) begin
                next_dat[DATA_W-1:0] = wd_high;
            end else if (hit_low) begin
                next_dat[DATA_W-1:0] = wd_low;
            end else if (hit_res) begin
                next_dat[DATA_W-1:0] = result;
            end
        end
    end

    // bus answer registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    // ---------------------------------------------------------------
    // software registers
    // ---------------------------------------------------------------
    // writes land at the edge where the ack is sampled
    always_comb begin
        next_ctrl1   = ctrl1;
        next_wd_high = wd_high;
        next_wd_low  = wd_low;
        next_result  = result;
        if (wr_take && hit_ctrl) begin
            next_ctrl1 = merged & adcsc_pkg::CTRL1_MASK;
        end
        if (wr_take && hit_high && wb_sel_i[0]) begin
            next_wd_high[7:0] = wb_dat_i[7:0];
        end
        if (wr_take && hit_high && wb_sel_i[1]) begin
            next_wd_high[DATA_W-1:8] = wb_dat_i[DATA_W-1:8];
        end
        if (wr_take && hit_low && wb_sel_i[0]) begin
            next_wd_low[7:0] = wb_dat_i[7:0];
        end
        if (wr_take && hit_low && wb_sel_i[1]) begin
            next_wd_low[DATA_W-1:8] = wb_dat_i[DATA_W-1:8];
        end
        if (conv_done && !conv_inj) begin
            next_result = conv_data;
        end
    end

    // software register file
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl1   <= adcsc_pkg::CTRL1_RST;
            wd_high <= DATA_W'(adcsc_pkg::WD_HIGH_RST);
            wd_low  <= DATA_W'(adcsc_pkg::WD_LOW_RST);
            result  <= DATA_W'(adcsc_pkg::RESULT_RST);
        end else begin
            ctrl1   <= next_ctrl1;
            wd_high <= next_wd_high;
            wd_low  <= next_wd_low;
            result  <= next_result;
        end
    end

    // ---------------------------------------------------------------
    // control fields towards the engine
    // ---------------------------------------------------------------
    // calibration voltage select
    assign calibration_voltage_select = ctrl1[adcsc_pkg::CAL_LSB +: 2];
    // channels per trigger, code plus one
    assign burst_channel_count = ctrl1[adcsc_pkg::BURST_CNT_LSB +: 3];
    assign injected_burst_mode_enable = ctrl1[adcsc_pkg::INJ_BURST];
    assign regular_burst_mode_enable = ctrl1[adcsc_pkg::REG_BURST];
    assign scan_enable = ctrl1[adcsc_pkg::SCAN];

    // ---------------------------------------------------------------
    // watchdog
    // ---------------------------------------------------------------
    // window check on the low threshold bits
    adcsc_window #(
        .DATA_W (DATA_W)
    ) u_window (
        .value   (conv_data),
        .high    (wd_high),
        .low     (wd_low),
        .outside (wd_outside)
    );

    assign wd_group_on = conv_inj ? ctrl1[adcsc_pkg::INJ_WD_EN]
                                  : ctrl1[adcsc_pkg::REG_WD_EN];
    assign wd_chan_on  = !ctrl1[adcsc_pkg::WD_SGL]
                      || (conv_channel == ctrl1[adcsc_pkg::WD_CH_LSB +: CH_W]);
    assign wd_event    = conv_done && wd_group_on && wd_chan_on && wd_outside;

    // ---------------------------------------------------------------
    // status flags
    // ---------------------------------------------------------------
    // hardware set and software clear terms per flag
    always_comb begin
        flag_set = '0;
        flag_set[adcsc_pkg::BIT_REG_START] = reg_start;
        flag_set[adcsc_pkg::BIT_INJ_START] = inj_start;
        flag_set[adcsc_pkg::BIT_INJ_DONE]  = conv_done && conv_inj && conv_last;
        flag_set[adcsc_pkg::BIT_CONV_DONE] = conv_done && conv_last;
        flag_set[adcsc_pkg::BIT_WATCHDOG]  = wd_event;
        // write 0 clears, write 1 keeps
        for (int i = 0; i < adcsc_pkg::STAT_W; i++) begin
            flag_clr[i] = wr_take && hit_stat && wb_sel_i[0] && !wb_dat_i[i];
        end
        if (rd_take && hit_res) begin
            flag_clr[adcsc_pkg::BIT_CONV_DONE] = 1'b1;
        end
    end

    // one sticky cell per flag
    for (genvar g = 0; g < adcsc_pkg::STAT_W; g++) begin : g_flag
        adcsc_flag u_flag (
            .clk      (clk),
            .rstn     (rstn),
            .hw_set   (flag_set[g]),
            .sw_clear (flag_clr[g]),
            .flag     (status[g])
        );
    end

    // ---------------------------------------------------------------
    // automatic injection
    // ---------------------------------------------------------------
    assign reg_group_end = conv_done && !conv_inj && conv_last;

    // start injected group after regular group
    always_comb begin
        next_auto = reg_group_end && ctrl1[adcsc_pkg::AUTO_INJ];
    end

    // start pulse register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            auto_inj_start <= 1'b0;
        end else begin
            auto_inj_start <= next_auto;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    reg_start_a: assert property (reg_start |=> status[4])
        else $error("regular start flag not set");
    inj_start_a: assert property (inj_start |=> status[3])
        else $error("injected start flag not set");
    inj_done_a: assert property ($rose(status[2]) |-> $past(conv_done && conv_inj && conv_last))
        else $error("injected done flag rose without group end");
    flag_clear_a: assert property (wr_take && hit_stat && wb_sel_i[0] && !wb_dat_i[4]
                                   && !reg_start |=> !status[4])
        else $error("write of zero did not clear flag");
    flag_keep_a: assert property (wr_take && hit_stat && wb_dat_i[3] && status[3]
                                  |=> status[3])
        else $error("write of one changed flag");
    conv_done_a: assert property (conv_done && conv_last |=> status[1])
        else $error("conversion done flag not set");
    result_clear_a: assert property (rd_take && hit_res && !(conv_done && conv_last)
                                     |=> !status[1])
        else $error("result read did not clear done flag");
    wd_hit_a: assert property (conv_done && !conv_inj && ctrl1[23] && !ctrl1[9]
                               && conv_data > wd_high |=> status[0])
        else $error("watchdog flag missed a high value");
    wd_off_a: assert property ($rose(status[0]) |-> $past(conv_done
                              && (conv_inj ? ctrl1[22] : ctrl1[23])))
        else $error("watchdog flag rose for a disabled group");
    wd_chan_a: assert property ($rose(status[0]) && $past(ctrl1[9])
                                |-> $past(conv_channel == ctrl1[4:0]))
        else $error("watchdog flag rose for another channel");
    auto_inj_a: assert property (reg_group_end && ctrl1[10] |=> auto_inj_start
                                 ##1 (!auto_inj_start || $past(reg_group_end && ctrl1[10])))
        else $error("auto injection start not one pulse");
    set_wins_a: assert property (reg_start && wr_take && hit_stat && wb_sel_i[0]
                                 |=> status[4])
        else $error("clear beat a hardware set");
    reserved_a: assert property (wb_ack_o && !wb_we_i && $past(hit_stat)
                                 |-> wb_dat_o[31:5] == 27'h0)
        else $error("reserved status bits not zero");
    cal_reset_a: assert property ($rose(rstn) |-> calibration_voltage_select == 2'h1)
        else $error("calibration field reset wrong");

    wd_hit_c: cover property (wd_event ##1 status[0]);
    result_rd_c: cover property (status[1] ##0 rd_take && hit_res ##1 !status[1]);
    auto_inj_c: cover property (auto_inj_start);
    ctrl_wr_c: cover property (wr_take && hit_ctrl);
endmodule // adcsc_top

// >>> rtl/adcsc_window.sv
// watchdog window check of one converted value
`timescale 1ns/1ps
module adcsc_window #(
    parameter int DATA_W = 10
) (
    // value and thresholds
    input  wire logic [DATA_W-1:0] value,
    input  wire logic [DATA_W-1:0] high,
    input  wire logic [DATA_W-1:0] low,
    // result
    output logic                   outside
);
    // outside when above high or below low
    assign outside = (value > high) || (value < low);
endmodule // adcsc_window
